// *** verilog/wwdt_pkg.sv ***
// constants shared by the windowed watchdog timer and its tick counter
// assumes one system clock; the counting clock arrives as a sampled input
package wwdt_pkg;
    localparam int SEL_W = 4;
    localparam int CNT_W = 16;
    localparam logic [7:0] KICK_KEY = 8'ha5;
    localparam int PERIOD_COUNT = 12;
    localparam logic [SEL_W-1:0] SEL_MAX = SEL_W'(PERIOD_COUNT - 1);
    localparam int PERIOD_MIN_MS = 8;
    localparam int PERIOD_MAX_S = 16;
    localparam int COUNT_RATE_HZ = 1000;
    // shortest period in counting-clock ticks, rounded up
    localparam int MIN_TICKS = (PERIOD_MIN_MS * COUNT_RATE_HZ + 999) / 1000;
    localparam logic RST_IRQ_EN = 1'b0;
    localparam logic [7:0] RST_KICK = 8'h00;
    localparam logic [SEL_W-1:0] RST_SEL = 4'h0;
endpackage

// *** verilog/wwdt_cnt_if.sv ***
// bundle between the watchdog control logic and its tick counter
// assumes both ends sit on the same system clock
`timescale 1ns/10ps
interface wwdt_cnt_if #(parameter int CNT_W = wwdt_pkg::CNT_W);
    logic step;
    logic clear;
    logic window_mode;
    logic [wwdt_pkg::SEL_W-1:0] period_sel;
    logic [wwdt_pkg::SEL_W-1:0] window_sel;
    logic [wwdt_pkg::SEL_W-1:0] offset_sel;
    logic in_closed;
    logic expire;
    logic warn_hit;
    logic [CNT_W-1:0] count;
    modport ctl (output step, clear, window_mode, period_sel, window_sel,
        offset_sel, input in_closed, expire, warn_hit, count);
    modport cnt (input step, clear, window_mode, period_sel, window_sel,
        offset_sel, output in_closed, expire, warn_hit, count);
endinterface

// *** verilog/wwdt_counter.sv ***
// tick counter of the watchdog: period decode, window and warning compares
// assumes step is a one-cycle pulse per counting-clock edge
`timescale 1ns/10ps
module wwdt_counter #(
    parameter int CNT_W = wwdt_pkg::CNT_W,
    parameter int MIN_TICKS = wwdt_pkg::MIN_TICKS
) (
    input wire logic i_clk,
    input wire logic i_srst,
    wwdt_cnt_if.cnt c
);
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] closed_len;
    logic [CNT_W-1:0] total_len;
    logic [CNT_W-1:0] warn_at;
    logic [CNT_W-1:0] next_count;

    if (MIN_TICKS < 1 ||
        CNT_W < $clog2(MIN_TICKS) + wwdt_pkg::PERIOD_COUNT + 1) begin : g_bad
        $error("wwdt_counter: counter too narrow for the longest period");
    end

    // out-of-range selects clamp to the longest period
    function automatic logic [CNT_W-1:0] span(
        input logic [wwdt_pkg::SEL_W-1:0] sel);
        logic [wwdt_pkg::SEL_W-1:0] s;
        s = (sel > wwdt_pkg::SEL_MAX) ? wwdt_pkg::SEL_MAX : sel;
        return CNT_W'(MIN_TICKS) << s;
    endfunction

    assign closed_len = c.window_mode ? span(c.window_sel) : '0;
    assign total_len = closed_len + span(c.period_sel);
    assign warn_at = c.window_mode ? closed_len : span(c.offset_sel);
    assign next_count = count + CNT_W'(1);
    assign c.in_closed = c.window_mode && (count < closed_len);
    assign c.expire = c.step && (next_count == total_len);
    // an offset past the timeout never fires: the reset comes first
    assign c.warn_hit = c.step && (next_count == warn_at);
    assign c.count = count;

    always_ff @(posedge i_clk) begin
        if (i_srst || c.clear) begin
            count <= '0;
        end else if (c.step) begin
            count <= next_count;
        end
    end

    clear_zero_a: assert property (@(posedge i_clk) disable iff (i_srst)
        c.clear |=> count == '0)
        else $error("count not zero after clear");

    count_step_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (c.step && !c.clear) |=> count == $past(count) + CNT_W'(1))
        else $error("count did not advance on step");
endmodule // wwdt_counter

// *** verilog/wwdt_top.sv ***
// windowed watchdog timer: settings, write synchronization, kick and reset
// assumes all inputs synchronous to i_clk, i_count_clk a slow sampled level
`timescale 1ns/10ps
module wwdt_top #(
    parameter int CNT_W = wwdt_pkg::CNT_W,
    parameter int MIN_TICKS = wwdt_pkg::MIN_TICKS
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_count_clk,
    input wire logic i_debug_halt,
    input wire logic i_access_lock,
    input wire logic i_row_enable,
    input wire logic i_row_wen,
    input wire logic i_row_persistent_run_lock,
    input wire logic [wwdt_pkg::SEL_W-1:0] i_row_window,
    input wire logic [wwdt_pkg::SEL_W-1:0] i_row_period,
    input wire logic [wwdt_pkg::SEL_W-1:0] i_row_offset,
    input wire logic i_ctrl_wr,
    input wire logic i_ctrl_enable,
    input wire logic i_ctrl_wen,
    input wire logic i_ctrl_persistent_run_lock,
    input wire logic i_cfg_wr,
    input wire logic [wwdt_pkg::SEL_W-1:0] i_cfg_window,
    input wire logic [wwdt_pkg::SEL_W-1:0] i_cfg_period,
    input wire logic i_warn_wr,
    input wire logic [wwdt_pkg::SEL_W-1:0] i_warn_offset,
    input wire logic i_irq_set,
    input wire logic i_irq_clr,
    input wire logic i_flag_clr,
    input wire logic i_kick_wr,
    input wire logic [7:0] i_kick_data,
    output logic o_enable,
    output logic o_wen,
    output logic o_persistent_run_lock,
    output logic [wwdt_pkg::SEL_W-1:0] o_window_sel,
    output logic [wwdt_pkg::SEL_W-1:0] o_period_sel,
    output logic [wwdt_pkg::SEL_W-1:0] o_offset_sel,
    output logic o_irq_en,
    output logic o_warn_flag,
    output logic o_sync_busy,
    output logic o_running,
    output logic o_irq,
    output logic o_sys_reset
);
    localparam int SW = wwdt_pkg::SEL_W;

    wwdt_cnt_if #(.CNT_W(CNT_W)) cif ();

    wwdt_counter #(.CNT_W(CNT_W), .MIN_TICKS(MIN_TICKS)) u_counter (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .c(cif.cnt)
    );

    logic row_loaded;
    logic cclk_prev;
    logic pend_ctrl;
    logic pend_cfg;
    logic pend_warn;
    logic pend_kick;
    logic [7:0] kick_key;
    logic act_enable;
    logic act_wen;
    logic act_persistent_run_lock;
    logic [SW-1:0] act_window;
    logic [SW-1:0] act_period;
    logic [SW-1:0] act_offset;

    // counting-clock edge, seen as a one-cycle tick in the system clock
    wire tick = i_count_clk && !cclk_prev;

    // write acceptance: user row must be loaded, no sync in flight, no lock; interrupt-enable strobes need only no lock
    wire wr_open = row_loaded && !o_sync_busy && !i_access_lock;
    wire ctrl_take = i_ctrl_wr && wr_open;
    wire cfg_take = i_cfg_wr && wr_open && !o_enable && !o_persistent_run_lock;
    wire warn_take = i_warn_wr && wr_open && !o_enable && !o_persistent_run_lock;
    wire kick_take = i_kick_wr && wr_open;
    wire irq_set_ok = i_irq_set && !i_access_lock;
    wire irq_clr_ok = i_irq_clr && !i_access_lock;

    // enable writes are ignored once always-on is set
    wire ctrl_enable_val = o_persistent_run_lock ? o_enable : i_ctrl_enable;
    // window enable: protected while enabled, but free under always-on
    wire wen_open = o_persistent_run_lock || !o_enable;
    wire ctrl_wen_val = wen_open ? i_ctrl_wen : o_wen;
    // always-on only sets, and only while disabled
    wire ctrl_on_val = o_persistent_run_lock || (i_ctrl_persistent_run_lock && !o_enable);

    wire next_enable = !row_loaded ? i_row_enable :
        ctrl_take ? ctrl_enable_val : o_enable;
    wire next_wen = !row_loaded ? i_row_wen :
        ctrl_take ? ctrl_wen_val : o_wen;
    wire next_persistent_run_lock = !row_loaded ? i_row_persistent_run_lock :
        ctrl_take ? ctrl_on_val : o_persistent_run_lock;
    wire [SW-1:0] next_window = !row_loaded ? i_row_window :
        cfg_take ? i_cfg_window : o_window_sel;
    wire [SW-1:0] next_period = !row_loaded ? i_row_period :
        cfg_take ? i_cfg_period : o_period_sel;
    wire [SW-1:0] next_offset = !row_loaded ? i_row_offset :
        warn_take ? i_warn_offset : o_offset_sel;

    // crossing writes are held pending and commit on the next tick, a kick on the next one outside debug halt
    wire ctrl_commit = tick && pend_ctrl;
    wire cfg_commit = tick && pend_cfg;
    wire warn_commit = tick && pend_warn;
    wire kick_done = tick && !i_debug_halt;
    wire next_pend_ctrl = ctrl_take || (pend_ctrl && !tick);
    wire next_pend_cfg = cfg_take || (pend_cfg && !tick);
    wire next_pend_warn = warn_take || (pend_warn && !tick);
    wire next_pend_kick = kick_take || (pend_kick && !kick_done);
    // a disable in flight keeps busy high, so protected writes wait it out
    wire next_busy = next_pend_ctrl || next_pend_cfg ||
        next_pend_warn || next_pend_kick;

    wire running = act_enable || act_persistent_run_lock;
    wire next_running = ctrl_commit ? (o_enable || o_persistent_run_lock) : running;
    wire kick_apply = kick_done && pend_kick && running && !o_sys_reset;
    wire key_good = (kick_key == wwdt_pkg::KICK_KEY);
    wire kick_ok = key_good && !cif.in_closed;
    wire kick_bad = kick_apply && !kick_ok;

    assign cif.window_mode = act_wen;
    assign cif.period_sel = act_period;
    assign cif.window_sel = act_window;
    assign cif.offset_sel = act_offset;
    // stopped or freshly enabled counters sit at zero
    assign cif.clear = !running || (kick_apply && kick_ok);
    assign cif.step = tick && running && !i_debug_halt &&
        !o_sys_reset && !kick_apply;

    wire fault = cif.expire || kick_bad;
    wire next_sys_reset = o_sys_reset || fault;
    // a new warning wins over a clear in the same cycle
    wire next_flag = cif.warn_hit || (o_warn_flag && !i_flag_clr);
    wire next_irq_en = irq_set_ok || (o_irq_en && !irq_clr_ok);
    wire next_irq = next_flag && next_irq_en;

    // the row is read on the first edge after reset release
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            row_loaded <= 1'b0;
            // follow the pin so a high level at release is no edge
            cclk_prev <= i_count_clk;
        end else begin
            row_loaded <= 1'b1;
            cclk_prev <= i_count_clk;
        end
    end

    // visible settings read back the written value at once
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_enable <= 1'b0;
            o_wen <= 1'b0;
            o_persistent_run_lock <= 1'b0;
        end else begin
            o_enable <= next_enable;
            o_wen <= next_wen;
            o_persistent_run_lock <= next_persistent_run_lock;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_window_sel <= wwdt_pkg::RST_SEL;
            o_period_sel <= wwdt_pkg::RST_SEL;
            o_offset_sel <= wwdt_pkg::RST_SEL;
        end else begin
            o_window_sel <= next_window;
            o_period_sel <= next_period;
            o_offset_sel <= next_offset;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            pend_ctrl <= 1'b0;
            pend_cfg <= 1'b0;
            pend_warn <= 1'b0;
            pend_kick <= 1'b0;
            o_sync_busy <= 1'b0;
        end else begin
            pend_ctrl <= next_pend_ctrl;
            pend_cfg <= next_pend_cfg;
            pend_warn <= next_pend_warn;
            pend_kick <= next_pend_kick;
            o_sync_busy <= next_busy;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            kick_key <= wwdt_pkg::RST_KICK;
        end else if (kick_take) begin
            kick_key <= i_kick_data;
        end
    end

    // working copies, used by the counter, change only on a tick or at the row load after reset
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            act_enable <= 1'b0;
            act_wen <= 1'b0;
            act_persistent_run_lock <= 1'b0;
        end else if (!row_loaded || ctrl_commit) begin
            act_enable <= next_enable;
            act_wen <= next_wen;
            act_persistent_run_lock <= next_persistent_run_lock;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            act_window <= wwdt_pkg::RST_SEL;
            act_period <= wwdt_pkg::RST_SEL;
        end else if (!row_loaded || cfg_commit) begin
            act_window <= next_window;
            act_period <= next_period;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            act_offset <= wwdt_pkg::RST_SEL;
        end else if (!row_loaded || warn_commit) begin
            act_offset <= next_offset;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_irq_en <= wwdt_pkg::RST_IRQ_EN;
            o_warn_flag <= 1'b0;
            o_irq <= 1'b0;
            o_sys_reset <= 1'b0;
            o_running <= 1'b0;
        end else begin
            o_irq_en <= next_irq_en;
            o_warn_flag <= next_flag;
            o_irq <= next_irq;
            o_sys_reset <= next_sys_reset;
            o_running <= (!row_loaded) ? (i_row_enable || i_row_persistent_run_lock)
                : next_running;
        end
    end

    busy_set_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_ctrl_wr && wr_open) |=> o_sync_busy)
        else $error("busy not raised after a control write");

    busy_stall_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (o_sync_busy && i_cfg_wr) |=> $stable(o_period_sel))
        else $error("settings changed during a pending sync");

    cfg_guard_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (row_loaded && o_enable) |=> $stable(o_window_sel))
        else $error("window setting changed while enabled");

    bad_key_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (kick_apply && kick_key != wwdt_pkg::KICK_KEY)
        |=> o_sys_reset)
        else $error("wrong key did not reset the system");

    early_kick_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (kick_apply && act_wen && cif.in_closed) |=> o_sys_reset)
        else $error("kick in closed window did not reset");

    halt_freeze_a: assert property (@(posedge i_clk) disable iff (i_srst)
        i_debug_halt |=> $stable(cif.count))
        else $error("count moved during debug halt");

    stopped_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (!running && row_loaded) |=> cif.count == '0)
        else $error("stopped watchdog still counting");

    persistent_run_lock_hold_a: assert property (@(posedge i_clk) disable iff (i_srst)
        o_persistent_run_lock |=> o_persistent_run_lock && o_enable == $past(o_enable))
        else $error("always-on dropped or enable changed");

    cfg_frozen_a: assert property (@(posedge i_clk) disable iff (i_srst)
        o_persistent_run_lock |=> $stable(o_period_sel) && $stable(o_offset_sel))
        else $error("settings changed under always-on");

    irq_level_a: assert property (@(posedge i_clk) disable iff (i_srst)
        o_irq == (o_warn_flag && o_irq_en))
        else $error("interrupt level disagrees with flag and enable");

    warn_flag_a: assert property (@(posedge i_clk) disable iff (i_srst)
        cif.warn_hit |=> o_warn_flag ##0 (o_irq == o_irq_en))
        else $error("warning hit did not set the flag");

    reset_sticky_a: assert property (@(posedge i_clk) disable iff (i_srst)
        o_sys_reset |=> o_sys_reset)
        else $error("reset request dropped before reset");

    expire_reset_a: assert property (@(posedge i_clk) disable iff (i_srst)
        cif.expire |=> o_sys_reset)
        else $error("timeout did not request a reset");

    kick_restart_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (kick_apply && kick_ok) |=> cif.count == '0)
        else $error("accepted kick did not restart the count");

    lock_hold_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (row_loaded && i_access_lock)
        |=> $stable(o_enable) && $stable(o_irq_en))
        else $error("locked setting changed");

    flag_clear_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_flag_clr && !cif.warn_hit) |=> !o_warn_flag)
        else $error("warning flag not cleared");

    irq_reset_a: assert property (@(posedge i_clk) disable iff (i_srst)
        $fell(i_srst) |-> !o_irq_en)
        else $error("warning interrupt enabled out of reset");

    irq_set_a: assert property (@(posedge i_clk) disable iff (i_srst)
        irq_set_ok |=> o_irq_en)
        else $error("enable-set strobe ignored");

    irq_clear_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (irq_clr_ok && !irq_set_ok) |=> !o_irq_en)
        else $error("enable-clear strobe ignored");

    row_load_a: assert property (@(posedge i_clk) disable iff (i_srst)
        !row_loaded |=> o_enable == $past(i_row_enable)
        && o_period_sel == $past(i_row_period))
        else $error("user row values not loaded");

    ao_window_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (ctrl_take && o_persistent_run_lock) |=> o_wen == $past(i_ctrl_wen))
        else $error("window enable not writable under always-on");

    tick_commit_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (row_loaded && !tick) |=> $stable(o_running))
        else $error("run state changed off a counting edge");

    busy_hold_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (o_sync_busy && !tick) |=> o_sync_busy)
        else $error("busy cleared without a counting edge");

    halt_kick_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_debug_halt && pend_kick) |=> pend_kick)
        else $error("kick applied during debug halt");
endmodule // wwdt_top

// *** verif/wwdt_far_model.sv ***
// far side of the watchdog: counting clock source and reset controller
// assumes the bench samples o_ticks and o_resets at falling edges
`timescale 1ns/10ps
module wwdt_far_model (
    input wire logic i_clk,
    input wire logic i_sys_reset,
    output logic o_count_clk = 1'b0,
    output int o_ticks = 0,
    output int o_resets = 0
);
    // start values on the declarations keep one process per output
    logic [2:0] div = 3'h0;
    logic last_rst = 1'b0;
    // free running, never gated, so always-on is only ever set while it runs
    always @(negedge i_clk) begin
        div <= div + 3'h1;
        o_count_clk <= div[2] ^ (div[1] & div[0]);
        if (div == 3'h3)
            o_ticks <= o_ticks + 1;
    end
    // the reset controller logs each new request level
    always @(posedge i_clk) begin
        last_rst <= i_sys_reset;
        if (i_sys_reset && !last_rst)
            o_resets <= o_resets + 1;
    end
endmodule // wwdt_far_model

// *** verif/windowed_watchdog_timer_tb_top.sv ***
// self-checking bench for the windowed watchdog timer
// assumes wwdt_top at a small tick scale beside the far-side model
`timescale 1ns/10ps
module windowed_watchdog_timer_tb_top;
    localparam int MT = 2;
    localparam int SW = wwdt_pkg::SEL_W;
    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    logic i_debug_halt = 1'b0, i_access_lock = 1'b0;
    logic i_row_enable = 1'b0, i_row_wen = 1'b0, i_row_persistent_run_lock = 1'b0;
    logic [SW-1:0] i_row_window = 4'h0, i_row_period = 4'h0;
    logic [SW-1:0] i_row_offset = 4'h0, i_warn_offset = 4'h0;
    logic i_ctrl_wr = 1'b0, i_ctrl_enable = 1'b0, i_ctrl_wen = 1'b0;
    logic i_ctrl_persistent_run_lock = 1'b0, i_cfg_wr = 1'b0, i_warn_wr = 1'b0;
    logic [SW-1:0] i_cfg_window = 4'h0, i_cfg_period = 4'h0;
    logic i_irq_set = 1'b0, i_irq_clr = 1'b0, i_flag_clr = 1'b0;
    logic i_kick_wr = 1'b0;
    logic [7:0] i_kick_data = 8'h00;
    logic i_count_clk;
    logic o_enable, o_wen, o_persistent_run_lock, o_irq_en, o_warn_flag, o_sync_busy;
    logic o_running, o_irq, o_sys_reset;
    logic [SW-1:0] o_window_sel, o_period_sel, o_offset_sel;
    int ticks, resets, rb, tf, tr, p, o;
    int bad_count = 0;
    int comparisons = 0;

    wwdt_top #(.MIN_TICKS(MT)) uut (
        .i_clk, .i_srst, .i_count_clk, .i_debug_halt, .i_access_lock,
        .i_row_enable, .i_row_wen, .i_row_persistent_run_lock, .i_row_window,
        .i_row_period, .i_row_offset, .i_ctrl_wr, .i_ctrl_enable,
        .i_ctrl_wen, .i_ctrl_persistent_run_lock, .i_cfg_wr, .i_cfg_window,
        .i_cfg_period, .i_warn_wr, .i_warn_offset, .i_irq_set, .i_irq_clr,
        .i_flag_clr, .i_kick_wr, .i_kick_data, .o_enable, .o_wen,
        .o_persistent_run_lock, .o_window_sel, .o_period_sel, .o_offset_sel,
        .o_irq_en, .o_warn_flag, .o_sync_busy, .o_running, .o_irq,
        .o_sys_reset
    );
    wwdt_far_model far (
        .i_clk, .i_sys_reset(o_sys_reset), .o_count_clk(i_count_clk),
        .o_ticks(ticks), .o_resets(resets)
    );

    initial begin
        forever #2.5 i_clk = ~i_clk;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // sticky reset output forces a fresh power-on for each test
    task automatic rst(input logic en, wen, ao, input logic [SW-1:0] w, pr,
                       ofs);
        @(negedge i_clk);
        {i_row_enable, i_row_wen, i_row_persistent_run_lock} = {en, wen, ao};
        {i_row_window, i_row_period, i_row_offset} = {w, pr, ofs};
        {i_debug_halt, i_access_lock} = 2'b00;
        i_srst = 1'b1;
        repeat (4) @(negedge i_clk);
        i_srst = 1'b0;
        repeat (3) @(negedge i_clk);
    endtask

    task automatic idle_wait();
        int n;
        n = 0;
        while (o_sync_busy !== 1'b0 && n < 200) begin
            @(negedge i_clk);
            n++;
        end
        if (n >= 200)
            chk("busy_wait", 1'b1, 1'b0);
    endtask

    // a strobe is raised only once busy is low, so busy never holds it off
    task automatic pulse(ref logic s);
        idle_wait();
        s = 1'b1;
        @(negedge i_clk);
        s = 1'b0;
    endtask

    task automatic ctrl(input logic en, wen, ao);
        {i_ctrl_enable, i_ctrl_wen, i_ctrl_persistent_run_lock} = {en, wen, ao};
        pulse(i_ctrl_wr);
        idle_wait();
    endtask

    task automatic cfg(input logic [SW-1:0] w, pr);
        {i_cfg_window, i_cfg_period} = {w, pr};
        pulse(i_cfg_wr);
        idle_wait();
    endtask

    task automatic wait_ticks(input int n);
        int t0;
        int c;
        t0 = ticks;
        c = 0;
        while (ticks < t0 + n && c < 3000) begin
            @(negedge i_clk);
            c++;
        end
        if (c >= 3000)
            chk("tick_wait", 1'b1, 1'b0);
    endtask

    // ticks from now until the warning flag and until the reset request
    task automatic run(output int t_warn, t_rst);
        int t0;
        int c;
        t0 = ticks;
        t_warn = -1;
        c = 0;
        while (o_sys_reset !== 1'b1 && c < 3000) begin
            @(negedge i_clk);
            c++;
            if (t_warn < 0 && o_warn_flag === 1'b1)
                t_warn = ticks - t0;
        end
        t_rst = ticks - t0;
    endtask

    initial begin
        #200000;
        bad_count++;
        close_out();
    end

    initial begin
        void'($urandom(32'hc53715ef));
        p = $urandom;
        rst(1'b0, p[0], 1'b0, p[7:4], p[11:8], p[15:12]);
        chk("wen", o_wen, p[0]);
        chk("window", o_window_sel, p[7:4]);
        chk("period", o_period_sel, p[11:8]);
        chk("offset", o_offset_sel, p[15:12]);
        chk("irq_en", o_irq_en, 1'b0);
        rst(1'b1, 1'b0, 1'b0, 4'h0, 4'h3, 4'h0);
        wait_ticks(2);
        chk("enable", o_enable, 1'b1);
        chk("running", o_running, 1'b1);
        ctrl(1'b0, 1'b0, 1'b0);
        chk("running", o_running, 1'b0);
        $display("test row_load done");

        p = 1 + $urandom_range(2);
        o = $urandom_range(p - 1);
        rst(1'b0, 1'b0, 1'b0, 4'h0, 4'h0, 4'h0);
        cfg(4'h0, p[3:0]);
        i_warn_offset = o[3:0];
        pulse(i_warn_wr);
        pulse(i_irq_set);
        chk("irq_en", o_irq_en, 1'b1);
        rb = resets;
        ctrl(1'b1, 1'b0, 1'b0);
        chk("running", o_running, 1'b1);
        run(tf, tr);
        chk("warn_at", tf, MT << o);
        chk("reset_at", tr, MT << p);
        chk("irq", o_irq, 1'b1);
        @(negedge i_clk);
        chk("requests", resets - rb, 1);
        i_access_lock = 1'b1;
        pulse(i_flag_clr);
        chk("flag", o_warn_flag, 1'b0);
        chk("irq", o_irq, 1'b0);
        chk("sys_reset", o_sys_reset, 1'b1);
        $display("test normal_timeout done");

        for (int k = 0; k < 2; k++) begin
            o = 1 + $urandom_range(254);
            rst(1'b0, 1'b0, 1'b0, 4'h0, 4'h2, 4'h0);
            ctrl(1'b1, 1'b0, 1'b0);
            wait_ticks(5);
            i_kick_data = (k == 1) ? 8'ha5 : (8'ha5 ^ o[7:0]);
            pulse(i_kick_wr);
            chk("busy", o_sync_busy, 1'b1);
            idle_wait();
            if (k == 0) begin
                chk("bad_key", o_sys_reset, 1'b1);
            end else begin
                run(tf, tr);
                chk("kick_restart", tr, MT << 2);
            end
        end
        $display("test kick done");

        rst(1'b0, 1'b0, 1'b0, 4'h0, 4'h0, 4'h0);
        cfg(4'h2, 4'h1);
        pulse(i_irq_set);
        ctrl(1'b1, 1'b1, 1'b0);
        run(tf, tr);
        chk("open_warn", tf, MT << 2);
        chk("window_total", tr, (MT << 2) + (MT << 1));
        rst(1'b0, 1'b0, 1'b0, 4'h0, 4'h0, 4'h0);
        cfg(4'h2, 4'h1);
        ctrl(1'b1, 1'b1, 1'b0);
        wait_ticks(1);
        i_kick_data = 8'ha5;
        pulse(i_kick_wr);
        idle_wait();
        chk("early_kick", o_sys_reset, 1'b1);
        $display("test window done");

        rst(1'b0, 1'b0, 1'b0, 4'h0, 4'h0, 4'h0);
        ctrl(1'b1, 1'b0, 1'b0);
        i_debug_halt = 1'b1;
        wait_ticks(6);
        chk("halt_reset", o_sys_reset, 1'b0);
        chk("halt_warn", o_warn_flag, 1'b0);
        i_debug_halt = 1'b0;
        run(tf, tr);
        chk("resume", tr, MT);
        $display("test debug_halt done");

        rst(1'b0, 1'b0, 1'b0, 4'h0, 4'h0, 4'h0);
        cfg(4'h1, 4'h2);
        ctrl(1'b1, 1'b0, 1'b0);
        cfg(4'h5, 4'h6);
        chk("window", o_window_sel, 4'h1);
        chk("period", o_period_sel, 4'h2);
        i_ctrl_enable = 1'b0;
        pulse(i_ctrl_wr);
        chk("busy", o_sync_busy, 1'b1);
        cfg(4'h3, 4'h4);
        chk("window", o_window_sel, 4'h3);
        chk("period", o_period_sel, 4'h4);
        i_access_lock = 1'b1;
        cfg(4'h7, 4'h7);
        pulse(i_irq_set);
        chk("window", o_window_sel, 4'h3);
        chk("irq_en", o_irq_en, 1'b0);
        $display("test protection done");

        rst(1'b0, 1'b0, 1'b0, 4'h0, 4'h3, 4'h1);
        ctrl(1'b0, 1'b0, 1'b1);
        chk("persistent_run_lock", o_persistent_run_lock, 1'b1);
        chk("running", o_running, 1'b1);
        ctrl(1'b0, 1'b1, 1'b0);
        chk("persistent_run_lock", o_persistent_run_lock, 1'b1);
        chk("wen", o_wen, 1'b1);
        chk("running", o_running, 1'b1);
        cfg(4'h5, 4'h5);
        chk("period", o_period_sel, 4'h3);
        i_warn_offset = 4'h5;
        pulse(i_warn_wr);
        idle_wait();
        chk("offset", o_offset_sel, 4'h1);
        pulse(i_irq_set);
        chk("irq_en", o_irq_en, 1'b1);
        pulse(i_irq_clr);
        chk("irq_en", o_irq_en, 1'b0);
        $display("test always_on done");
        close_out();
    end
endmodule // windowed_watchdog_timer_tb_top
